// File: inc/nfc_pkg.sv
// Package for the host-side NOR flash controller: pin timing counts, command
// codes and address constants. Assumes a 200 MHz system clock.
package nfc_pkg;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    // Reset pulse and wake-up figures
    localparam int unsigned RST_LOW_NS = 500;
    localparam int unsigned RST_LOW_CYC = (RST_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned WAKE_NS = 200;
    localparam int unsigned WAKE_CYC = (WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned ABORT_US = 20;
    localparam int unsigned ABORT_CYC = (ABORT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Bus cycle phase length (setup, strobe, hold), plain default
    localparam int unsigned PHASE_CYC = 16;
    // Command codes
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_UNLK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLK2 = 8'h55;
    localparam logic [7:0] CMD_SEC_ENTER = 8'h88;
    localparam logic [7:0] CMD_SEC_EXIT = 8'h90;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_EXIT_2 = 8'h00;
    // Query entry addresses for word and byte mode
    localparam logic [20:0] QUERY_ADDR_WORD = 21'h000055;
    localparam logic [20:0] QUERY_ADDR_BYTE = 21'h0000AA;
    localparam logic [20:0] UNLK_ADDR1 = 21'h000555;
    localparam logic [20:0] UNLK_ADDR2 = 21'h0002AA;
    // Secure region word and byte windows
    localparam logic [20:0] SEC_TOP_WORD_LO = 21'h1F8000;
    localparam logic [20:0] SEC_TOP_BYTE_LO = 21'h3F0000;
    localparam logic [20:0] SEC_BOT_BYTE_HI = 21'h00FFFF;
    localparam int unsigned SEC_IND_BIT = 7;
    localparam int unsigned TMO_BIT = 5;
    // User operations
    typedef enum logic [2:0] {
        NFC_OP_READ, NFC_OP_WRITE, NFC_OP_RESET_CMD, NFC_OP_QUERY,
        NFC_OP_SEC_ENTER, NFC_OP_SEC_EXIT, NFC_OP_ACC_PROG, NFC_OP_HW_RESET
    } nfc_op_t;
endpackage : nfc_pkg

// File: design/nfc_seq_rom.sv
// Small command-sequence memory: per operation and step, the address and data
// written to the flash. Registered read data; used by the bus sequencer.
`timescale 1ns/1ps
module nfc_seq_rom
    import nfc_pkg::*;
(
    input wire logic i_sys_clk,           // System clock
    input wire logic i_rst_n,             // Async reset, active low
    input wire logic [2:0] i_op,          // Operation code
    input wire logic [1:0] i_step,        // Step within the sequence
    input wire logic i_byte_mode,         // Flash in x8 mode
    output logic [20:0] o_addr,           // Registered step address
    output logic [7:0] o_data,            // Registered step data
    output logic o_last                   // Registered last-step flag
);
    logic [20:0] addr_w;
    logic [7:0] data_w;
    logic last_w;
    wire [20:0] query_addr = i_byte_mode ? QUERY_ADDR_BYTE : QUERY_ADDR_WORD;

    // Unlock cycles are shared by the secure-region sequences
    always_comb begin
        addr_w = UNLK_ADDR1;
        data_w = CMD_RESET;
        last_w = 1'b1;
        unique case (nfc_op_t'(i_op))
            NFC_OP_QUERY: begin
                addr_w = query_addr;
                data_w = CMD_QUERY;
            end
            NFC_OP_SEC_ENTER, NFC_OP_SEC_EXIT: begin
                unique case (i_step)
                    2'd0: begin addr_w = UNLK_ADDR1; data_w = CMD_UNLK1; last_w = 1'b0; end
                    2'd1: begin addr_w = UNLK_ADDR2; data_w = CMD_UNLK2; last_w = 1'b0; end
                    2'd2: begin
                        addr_w = UNLK_ADDR1;
                        data_w = (nfc_op_t'(i_op) == NFC_OP_SEC_ENTER) ? CMD_SEC_ENTER : CMD_SEC_EXIT;
                        last_w = (nfc_op_t'(i_op) == NFC_OP_SEC_ENTER);
                    end
                    default: begin addr_w = UNLK_ADDR1; data_w = CMD_EXIT_2; end
                endcase
            end
            default: begin
                addr_w = UNLK_ADDR1;
                data_w = CMD_RESET;
            end
        endcase
    end

    // Registered outputs, as a synchronous ROM
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_addr <= 21'h000000;
            o_data <= 8'h00;
            o_last <= 1'b0;
        end else begin
            o_addr <= addr_w;
            o_data <= data_w;
            o_last <= last_w;
        end
    end
endmodule : nfc_seq_rom

// File: design/nfc_host_ctrl.sv
// Host-side controller for a dual-bank asynchronous NOR flash: drives the
// chip pins (address, data, strobes, reset, protect/accelerate) from a user port.
// Assumes the flash pins are asynchronous; all returned levels pass two flops.
`timescale 1ns/1ps
module nfc_host_ctrl
    import nfc_pkg::*;
#(
    parameter int unsigned ABORT_WAIT = ABORT_CYC,   // Standby wait after reset pulse
    parameter int unsigned PHASE = PHASE_CYC         // Cycles per bus phase
) (
    input wire logic i_sys_clk,           // System clock, 200 MHz
    input wire logic i_rst_n,             // Async reset, active low
    input wire logic i_req,               // Request strobe, one cycle
    input wire logic [2:0] i_op,          // Operation, nfc_op_t
    input wire logic [20:0] i_addr,       // Flash address
    input wire logic [15:0] i_wdata,      // Write data
    input wire logic i_byte_mode,         // Flash strapped for x8
    input wire logic i_wp_protect,        // Hold protect pin low
    input wire logic [15:0] i_fl_dq,      // Flash data pins in
    output logic o_busy,                  // Operation in progress
    output logic o_done,                  // Operation finished, one cycle
    output logic [15:0] o_rdata,          // Read data
    output logic o_sec_mode,              // Host believes secure region selected
    output logic o_query_mode,            // Host believes query mode active
    output logic [20:0] o_fl_addr,        // Flash address pins
    output logic [15:0] o_fl_dq,          // Flash data pins out
    output logic o_fl_dq_oe,              // Data drive enable, high drives
    output logic o_fl_ce_n,               // Chip select, active low
    output logic o_fl_oe_n,               // Output enable, active low
    output logic o_fl_we_n,               // Write enable, active low
    output logic o_fl_reset_n,            // Reset pin, active low
    output logic o_fl_wp_n,               // Protect pin logic level
    output logic o_fl_acc_hv              // Request acceleration high level
);
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_RST_LOW, S_RST_WAKE, S_ABORT} nfc_state_t;

    localparam int unsigned CNT_W = $clog2(ABORT_WAIT + RST_LOW_CYC + 2);

    // Elaboration-time refusal of settings the sequencer cannot serve
    if (PHASE < 2 || ABORT_WAIT < 1) begin : g_bad_param
        $error("nfc_host_ctrl: PHASE must be >= 2 and ABORT_WAIT >= 1");
    end

    nfc_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [1:0] step_r;
    nfc_op_t op_r;
    logic [20:0] uaddr_r;
    logic [15:0] uwdata_r;
    logic [15:0] dq_s1_r, dq_s2_r;
    logic [20:0] rom_addr;
    logic [7:0] rom_data;
    logic rom_last;
    logic [1:0] step_nxt;

    // Next-cycle view of the request: the pins are registered from these, so the
    // first bus cycle shows the new operation and not the previous one
    wire take = (state_r == S_IDLE) && i_req;
    wire [2:0] op_nxt = take ? i_op : op_r;
    wire [20:0] uaddr_nxt = take ? i_addr : uaddr_r;
    wire [15:0] uwdata_nxt = take ? i_wdata : uwdata_r;

    // Sequence memory holds unlock and command cycles; fed one cycle ahead to hide its read register
    nfc_seq_rom u_rom (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_op(op_nxt),
        .i_step(step_nxt),
        .i_byte_mode(i_byte_mode),
        .o_addr(rom_addr),
        .o_data(rom_data),
        .o_last(rom_last)
    );

    // Decoded operation classes
    wire op_is_read = (op_nxt == NFC_OP_READ);
    wire op_is_user = (op_nxt == NFC_OP_READ) || (op_nxt == NFC_OP_WRITE) || (op_nxt == NFC_OP_ACC_PROG);
    wire op_is_acc = (op_nxt == NFC_OP_ACC_PROG);
    wire phase_end = (cnt_r == CNT_W'(PHASE - 1));
    assign step_nxt = (state_r == S_IDLE) ? 2'd0 : (state_r == S_HOLD && phase_end) ? step_r + 2'd1 : step_r;
    wire seq_last = op_is_user ? 1'b1 : rom_last;
    wire [20:0] cyc_addr = op_is_user ? uaddr_nxt : rom_addr;
    wire [15:0] cyc_data = op_is_user ? uwdata_nxt : {8'h00, rom_data};
    // Query data live on the low byte only, so upper bits are cleared
    wire [15:0] rd_value = o_query_mode ? {8'h00, dq_s2_r[7:0]} : dq_s2_r;
    wire rst_low_end = (cnt_r == CNT_W'(RST_LOW_CYC - 1));
    wire wake_end = (cnt_r == CNT_W'(WAKE_CYC - 1));
    wire abort_end = (cnt_r == CNT_W'(ABORT_WAIT - 1));

    // Two flops on the returned data pins, since the flash is unclocked
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dq_s1_r <= 16'h0000;
            dq_s2_r <= 16'h0000;
        end else begin
            dq_s1_r <= i_fl_dq;
            dq_s2_r <= dq_s1_r;
        end
    end

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            S_IDLE: begin
                if (i_req) state_nxt = (nfc_op_t'(i_op) == NFC_OP_HW_RESET) ? S_RST_LOW : S_SETUP;
            end
            S_SETUP: if (phase_end) state_nxt = S_STROBE;
            S_STROBE: if (phase_end) state_nxt = S_HOLD;
            S_HOLD: if (phase_end) state_nxt = seq_last ? S_IDLE : S_SETUP;
            S_RST_LOW: if (rst_low_end) state_nxt = S_ABORT;
            S_ABORT: if (abort_end) state_nxt = S_RST_WAKE;
            S_RST_WAKE: if (wake_end) state_nxt = S_IDLE;
        endcase
    end

    // State, counter and step
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= S_IDLE;
            cnt_r <= '0;
            step_r <= 2'd0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= (state_nxt != state_r) ? '0 : cnt_r + 1'b1;
            step_r <= step_nxt;
        end
    end

    // Latch the request; op stays until the next request
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            op_r <= NFC_OP_READ;
            uaddr_r <= 21'h000000;
            uwdata_r <= 16'h0000;
        end else if (state_r == S_IDLE && i_req) begin
            op_r <= nfc_op_t'(i_op);
            uaddr_r <= i_addr;
            uwdata_r <= i_wdata;
        end
    end

    // Pin drive: write strobe only with CE low, WE low and OE high
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fl_ce_n <= 1'b1;
            o_fl_oe_n <= 1'b1;
            o_fl_we_n <= 1'b1;
            o_fl_addr <= 21'h000000;
            o_fl_dq <= 16'h0000;
            o_fl_dq_oe <= 1'b0;
        end else begin
            o_fl_ce_n <= !(state_nxt inside {S_SETUP, S_STROBE, S_HOLD});
            o_fl_oe_n <= !(op_is_read && state_nxt == S_STROBE);
            o_fl_we_n <= !(!op_is_read && state_nxt == S_STROBE);
            o_fl_addr <= cyc_addr;
            o_fl_dq <= cyc_data;
            // Never drive data while the flash is in reset, it floats its outputs
            o_fl_dq_oe <= !op_is_read && (state_nxt inside {S_SETUP, S_STROBE, S_HOLD});
        end
    end

    // Reset pin and protect/accelerate drive as decoded digital requests
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fl_reset_n <= 1'b0;
            o_fl_wp_n <= 1'b0;
            o_fl_acc_hv <= 1'b0;
        end else begin
            o_fl_reset_n <= (state_nxt != S_RST_LOW);
            o_fl_wp_n <= !i_wp_protect;
            // High level only for the accelerated two-cycle program burst
            o_fl_acc_hv <= op_is_acc && (state_nxt inside {S_SETUP, S_STROBE, S_HOLD});
        end
    end

    // Host mode tracking; the sticky secure mode is cleared only by exit or hardware reset
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sec_mode <= 1'b0;
            o_query_mode <= 1'b0;
        end else if (state_r == S_RST_LOW) begin
            o_sec_mode <= 1'b0;
            o_query_mode <= 1'b0;
        end else if (state_r == S_HOLD && phase_end) begin
            if (op_r == NFC_OP_SEC_ENTER) o_sec_mode <= 1'b1;
            if (op_r == NFC_OP_SEC_EXIT) o_sec_mode <= 1'b0;
            if (op_r == NFC_OP_QUERY) o_query_mode <= 1'b1;
            if (op_r == NFC_OP_RESET_CMD) o_query_mode <= 1'b0;
        end
    end

    // Completion, busy and read capture
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_rdata <= 16'h0000;
        end else begin
            o_busy <= (state_nxt != S_IDLE);
            o_done <= (state_r != S_IDLE) && (state_nxt == S_IDLE);
            if (state_r == S_STROBE && phase_end && op_is_read) o_rdata <= rd_value;
        end
    end
endmodule : nfc_host_ctrl

// File: sim/nfc_host_ctrl_props.sv
// Concurrent checks on the controller's flash pins and its user handshake.
// Assumes it is bound into nfc_host_ctrl with the parameters handed on.
`timescale 1ns/1ps
module nfc_host_ctrl_props
    import nfc_pkg::*;
#(
    parameter int unsigned ABORT_WAIT = 10, // Standby wait
    parameter int unsigned PHASE = 4        // Cycles per bus phase
) (
    input wire logic i_sys_clk,        // Clock
    input wire logic i_rst_n,          // Reset, active low
    input wire logic i_req,            // Request
    input wire logic [2:0] i_op,       // Operation
    input wire logic [20:0] i_addr,    // User address
    input wire logic i_byte_mode,      // x8 strap
    input wire logic i_wp_protect,     // Protect request
    input wire logic o_busy,           // Busy
    input wire logic [20:0] o_fl_addr, // Flash address
    input wire logic [15:0] o_fl_dq,   // Flash data out
    input wire logic o_fl_dq_oe,       // Data drive
    input wire logic o_fl_ce_n,        // Chip select
    input wire logic o_fl_oe_n,        // Output enable
    input wire logic o_fl_we_n,        // Write enable
    input wire logic o_fl_reset_n,     // Flash reset
    input wire logic o_fl_wp_n,        // Protect pin
    input wire logic o_fl_acc_hv       // Acceleration level
);
    localparam int PH = PHASE;
    localparam int PH1 = PHASE + 1;
    logic [7:0] low_cnt_r;  // Cycles the flash reset pin has been low
    logic [7:0] wake_cnt_r; // Cycles since that pin was released
    logic seen_hi_r;        // Pin has been high since power-up
    // Power-up low time is no host pulse, so both counters start satisfied
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_cnt_r <= 8'h64;
            wake_cnt_r <= 8'h28;
            seen_hi_r <= 1'b0;
        end else begin
            seen_hi_r <= seen_hi_r | o_fl_reset_n;
            low_cnt_r <= o_fl_reset_n ? 8'h00 : low_cnt_r + {7'h00, low_cnt_r != 8'hFF};
            wake_cnt_r <= (!o_fl_reset_n && seen_hi_r) ? 8'h00 :
                wake_cnt_r + {7'h00, o_fl_reset_n && wake_cnt_r != 8'hFF};
        end
    end
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    // Request taken while idle
    sequence s_take(logic [2:0] op);
        i_req && !o_busy && i_op == op;
    endsequence
    // Address phase of one write cycle
    sequence s_wr_setup;
        !o_fl_ce_n && o_fl_we_n && o_fl_dq_oe && o_fl_addr == $past(i_addr);
    endsequence
    AST_WE_QUAL: assert property (!o_fl_we_n |-> !o_fl_ce_n && o_fl_oe_n)
        else $error("Write strobe outside a qualified cycle");
    AST_OE_NODRV: assert property (!o_fl_oe_n |-> !o_fl_dq_oe)
        else $error("Host drives data during a read");
    AST_WR_WALK: assert property (s_take(NFC_OP_WRITE) |-> ##1 s_wr_setup ##PH !o_fl_we_n)
        else $error("Write cycle walk broken");
    AST_RST_LEN: assert property ($rose(o_fl_reset_n) |-> low_cnt_r >= 8'h64)
        else $error("Flash reset pulse too short");
    AST_WAKE: assert property (!o_fl_oe_n |-> wake_cnt_r >= 8'h28)
        else $error("Read before wake-up time");
    AST_DQZ_RST: assert property (!o_fl_reset_n |-> !o_fl_dq_oe && o_fl_ce_n)
        else $error("Bus active during flash reset");
    AST_QRY: assert property (s_take(NFC_OP_QUERY) |-> ##PH1 (!o_fl_we_n &&
        o_fl_dq[7:0] == CMD_QUERY && o_fl_addr == (i_byte_mode ? QUERY_ADDR_BYTE : QUERY_ADDR_WORD)))
        else $error("Query entry cycle wrong");
    AST_ACC_REQ: assert property (s_take(NFC_OP_ACC_PROG) |-> ##[1:PH] o_fl_acc_hv)
        else $error("Acceleration level not requested");
    AST_WP_PIN: assert property ($past(i_rst_n) |-> o_fl_wp_n == !$past(i_wp_protect))
        else $error("Protect pin does not follow request");
endmodule : nfc_host_ctrl_props

bind nfc_host_ctrl nfc_host_ctrl_props #(.ABORT_WAIT(ABORT_WAIT), .PHASE(PHASE)) i_props (.*);

// File: sim/nfc_flash_model.sv
// Behavioural bottom-boot NOR flash seen at its pins, word mode.
// Assumes a host that resolves the shared data wire and feeds it back here.
`timescale 1ns/1ps
module nfc_flash_model
    import nfc_pkg::*;
#(
    parameter int RD_DLY = 3,                  // Read access delay in ns
    parameter logic [15:0] SEC_FILL = 16'h5A3C // Secure pattern, arbitrary
) (
    input wire logic [20:0] i_addr, // Address pins
    input wire logic [15:0] i_dq,   // Data wire level
    input wire logic i_ce_n,        // Chip select
    input wire logic i_oe_n,        // Output enable
    input wire logic i_we_n,        // Write enable
    input wire logic i_reset_n,     // Reset pin
    input wire logic i_wp_n,        // Protect pin
    input wire logic i_acc_hv,      // Decoded acceleration level
    output logic [15:0] o_dq        // Data from the flash
);
    logic [15:0] mem [int];
    logic [15:0] last_q = 16'h0000;
    logic [7:0] d;
    logic qry = 1'b0;
    logic sec = 1'b0;
    logic upd = 1'b0;
    int st = 0;
    wire drive = !i_ce_n && !i_oe_n && i_reset_n;
    // Query, secure window, then array
    function automatic logic [15:0] rd_word(input logic [20:0] x);
        if (qry) return {8'h00, x == 21'h10 ? 8'h51 : x == 21'h11 ? 8'h52 : x == 21'h12 ? 8'h59 : 8'h00};
        if (sec && x < 21'h008000) return SEC_FILL ^ x[15:0];
        return mem.exists(x) ? mem[x] : 16'hFFFF;
    endfunction : rd_word
    // Released bus shows the inverse of the last word, never a held value
    always @(i_addr or drive or upd) begin
        if (drive) last_q = rd_word(i_addr);
    end
    assign #(RD_DLY) o_dq = drive ? last_q : ~last_q;
    // Command decoder on write-enable rise; reset pin returns read mode
    always @(posedge i_we_n or negedge i_reset_n) begin
        upd = ~upd;
        d = i_dq[7:0];
        if (!i_reset_n) begin
            qry = 1'b0;
            sec = 1'b0;
            st = 0;
        end else if (!i_ce_n && i_oe_n) begin
            if (st == 3) begin
                // Lowest two blocks are the boot pair; acceleration lifts protection
                // Two 8K-byte blocks are 2000H words in word mode
                if (!sec && (i_wp_n || i_acc_hv || i_addr >= 21'h002000))
                    mem[i_addr] = rd_word(i_addr) & i_dq;
                st = 0;
            end else if (d == CMD_RESET) begin
                st = 0;
                qry = 1'b0;
            end else if (d == CMD_QUERY && i_addr[7:0] inside {8'h55, 8'hAA}) qry = 1'b1;
            else if (st == 0 && d == CMD_UNLK1 && i_addr == UNLK_ADDR1) st = 1;
            else if (st == 1 && d == CMD_UNLK2 && i_addr == UNLK_ADDR2) st = 2;
            else if (st == 2 && d == CMD_SEC_ENTER) begin
                sec = 1'b1;
                st = 0;
            end else if (st == 2 && d == CMD_SEC_EXIT) st = 4;
            else if (st == 4 && d == CMD_EXIT_2) begin
                sec = 1'b0;
                st = 0;
            end else if ((st == 2 || i_acc_hv) && d == CMD_PROGRAM) st = 3;
            else st = 0;
        end
    end
endmodule : nfc_flash_model

// File: sim/tb_top.sv
// Self-checking bench: host controller driving a behavioural flash.
// Assumes word mode and the model's bottom-boot map.
`timescale 1ns/1ps
module tb_top;
    import nfc_pkg::*;
    localparam logic [15:0] SEC = 16'h5A3C;
    `define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
        $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
    logic i_sys_clk = 1'b0;
    logic i_rst_n, i_req, i_byte_mode, i_wp_protect;
    logic [2:0] i_op;
    logic [20:0] i_addr, o_fl_addr, a;
    logic [15:0] i_wdata, o_rdata, o_fl_dq, fl_dq, flash_dq, d;
    logic o_busy, o_done, o_sec_mode, o_query_mode, o_fl_dq_oe, o_fl_ce_n;
    logic o_fl_oe_n, o_fl_we_n, o_fl_reset_n, o_fl_wp_n, o_fl_acc_hv;
    logic [15:0] exp_mem [int];
    int fail_count = 0;
    int compares = 0;
    int seed;
    // Shared wire: host data while it drives, otherwise the flash
    assign fl_dq = o_fl_dq_oe ? o_fl_dq : flash_dq;
    always #2.5 i_sys_clk = ~i_sys_clk;
    nfc_host_ctrl #(.ABORT_WAIT(10), .PHASE(4)) i_dut (.*, .i_fl_dq(fl_dq));
    nfc_flash_model #(.RD_DLY(7), .SEC_FILL(SEC)) i_flash (.i_addr(o_fl_addr), .i_dq(fl_dq),
        .i_ce_n(o_fl_ce_n), .i_oe_n(o_fl_oe_n), .i_we_n(o_fl_we_n), .i_reset_n(o_fl_reset_n),
        .i_wp_n(o_fl_wp_n), .i_acc_hv(o_fl_acc_hv), .o_dq(flash_dq));
    function automatic logic [15:0] ex(input logic [20:0] x);
        return exp_mem.exists(x) ? exp_mem[x] : 16'hFFFF;
    endfunction : ex
    task automatic report_and_stop();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    // One request pulse, then a bounded wait for completion
    task automatic run(input logic [2:0] op, input logic [20:0] x, input logic [15:0] v);
        int n = 0;
        @(negedge i_sys_clk);
        i_req = 1'b1;
        i_op = op;
        i_addr = x;
        i_wdata = v;
        @(negedge i_sys_clk);
        i_req = 1'b0;
        `CHK(o_busy, 1'b1)
        while (o_done !== 1'b1 && n < 2000) begin
            @(negedge i_sys_clk);
            n++;
        end
        if (n >= 2000) fail_count++;
    endtask : run
    task automatic rd(input logic [20:0] x, input logic [15:0] e);
        run(NFC_OP_READ, x, 16'h0000);
        `CHK(o_rdata, e)
    endtask : rd
    task automatic prog(input logic [20:0] x, input logic [15:0] v, input bit ok);
        run(NFC_OP_WRITE, UNLK_ADDR1, {8'h00, CMD_UNLK1});
        run(NFC_OP_WRITE, UNLK_ADDR2, {8'h00, CMD_UNLK2});
        if (ok) exp_mem[x] = ex(x) & v;
        run(NFC_OP_WRITE, UNLK_ADDR1, {8'h00, CMD_PROGRAM});
        run(NFC_OP_WRITE, x, v);
    endtask : prog
    initial begin
        {i_rst_n, i_req, i_byte_mode, i_wp_protect, i_op, i_addr, i_wdata} = '0;
        repeat (10) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        seed = $urandom(32'h426C3499);
        for (int i = 0; i < 6; i++) begin
            a = 21'h002000 | 21'($urandom_range(32'h000FFFFF));
            prog(a, 16'($urandom), 1);
            rd(a, ex(a));
        end
        // Protected boot pair edge, first open block, then acceleration
        i_wp_protect = 1'b1;
        prog(21'h001FFF, 16'h1234, 0);
        rd(21'h001FFF, 16'hFFFF);
        prog(21'h002000, 16'h1234, 1);
        rd(21'h002000, ex(21'h002000));
        a = 21'($urandom_range(32'h1FFF));
        d = 16'($urandom);
        run(NFC_OP_ACC_PROG, a, {8'h00, CMD_PROGRAM});
        run(NFC_OP_ACC_PROG, a, d);
        exp_mem[a] = ex(a) & d;
        rd(a, ex(a));
        i_wp_protect = 1'b0;
        prog(21'h000FFF, 16'h00FF, 1);
        rd(21'h000FFF, ex(21'h000FFF));
        // Reset command after the unlock cycles drops the sequence
        run(NFC_OP_WRITE, UNLK_ADDR1, {8'h00, CMD_UNLK1});
        run(NFC_OP_WRITE, UNLK_ADDR2, {8'h00, CMD_UNLK2});
        run(NFC_OP_RESET_CMD, 21'($urandom), 16'h0000);
        run(NFC_OP_WRITE, 21'h002000, 16'h0000);
        rd(21'h002000, ex(21'h002000));
        run(NFC_OP_QUERY, 21'h000000, 16'h0000);
        `CHK(o_query_mode, 1'b1)
        rd(21'h000010, 16'h0051);
        rd(21'h000012, 16'h0059);
        run(NFC_OP_RESET_CMD, 21'h000000, 16'h0000);
        `CHK(o_query_mode, 1'b0)
        rd(21'h000010, ex(21'h000010));
        // Byte-mode query entry uses the other entry address
        i_byte_mode = 1'b1;
        run(NFC_OP_QUERY, 21'h000000, 16'h0000);
        rd(21'h000010, 16'h0051);
        run(NFC_OP_RESET_CMD, 21'h000000, 16'h0000);
        `CHK(o_query_mode, 1'b0)
        i_byte_mode = 1'b0;
        // Secure window left once by exit command, once by hardware reset
        for (int k = 0; k < 2; k++) begin
            run(NFC_OP_SEC_ENTER, 21'h000000, 16'h0000);
            `CHK(o_sec_mode, 1'b1)
            a = 21'($urandom_range(32'h7FFF));
            rd(a, SEC ^ a[15:0]);
            run(k ? 3'(NFC_OP_HW_RESET) : 3'(NFC_OP_SEC_EXIT), 21'h000000, 16'h0000);
            `CHK(o_sec_mode, 1'b0)
            rd(a, ex(a));
        end
        report_and_stop();
    end
    // Watchdog well beyond the expected run of under two thousand cycles
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
endmodule : tb_top
